//--- verilog/align_pkg.sv
package align_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned HOLD_MIN_US = 1000;
	localparam int unsigned RELOCK_US = 500;
	localparam int unsigned SETTLE_NS = 2000;
	localparam int unsigned LOCK_MIN_NS = 1000;
	localparam int unsigned NS_PER_US = 1000;

	localparam int unsigned CNT_W = 32;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

	// Least times round up to whole cycles
	localparam logic [CNT_W-1:0] HOLD_MIN_CYC =
		CNT_W'((HOLD_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RELOCK_CYC =
		CNT_W'((RELOCK_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] SETTLE_CYC =
		CNT_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] LOCK_MIN_CYC =
		CNT_W'((LOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Trailer dividers
	localparam int unsigned NUM_OUT = 4;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [DIV_W-1:0] DIV_MIN = 8'h02;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;

	typedef enum logic [3:0] {
		T_IDLE = 4'b0001,
		T_INIT = 4'b0010,
		T_FROZEN = 4'b0100,
		T_ARM = 4'b1000
	} trailer_state_t;

	typedef enum logic [5:0] {
		L_IDLE = 6'b00_0001,
		L_S1_INIT = 6'b00_0010,
		L_S1_DONE = 6'b00_0100,
		L_RELOCK = 6'b00_1000,
		L_S2_INIT = 6'b01_0000,
		L_S2_DONE = 6'b10_0000
	} leader_state_t;

endpackage

//--- verilog/align_if.sv
`timescale 1ns/1ns
`default_nettype none
interface align_if;
	logic multiFunctionAlignPin;
	logic softwareAlignBit;
	logic locked;
	modport leader(output multiFunctionAlignPin, output softwareAlignBit, input locked);
	modport trailer(input multiFunctionAlignPin, input softwareAlignBit, output locked);
endinterface
`default_nettype wire

//--- verilog/cascade_trailer.sv
`timescale 1ns/1ns
`default_nettype none
module cascade_trailer #(
	parameter bit LOOP_PART = 1'b1
) (
	input wire logic core_clk,
	input wire logic srst,
	align_if.trailer link,
	input wire logic [align_pkg::DIV_W-1:0] loopFeedbackDivider,
	input wire logic [align_pkg::NUM_OUT-1:0][align_pkg::DIV_W-1:0] divRatio,
	input wire logic pllLocked,
	output logic [align_pkg::NUM_OUT-1:0] clkOut,
	output logic [align_pkg::NUM_OUT-1:0] frozen,
	output logic fbOut,
	output align_pkg::trailer_state_t phase
);
	import align_pkg::*;

	typedef struct packed {
		trailer_state_t state;
		logic [SYNC_STAGES-1:0] sync;
		logic reqRetimed;
		logic reqPrev;
		logic [DIV_W-1:0] fbCnt;
		logic fbOut;
		logic [NUM_OUT-1:0][DIV_W-1:0] cnt;
		logic [NUM_OUT-1:0] out;
		logic [NUM_OUT-1:0] frozen;
		logic locked;
	} trailer_t;

	localparam trailer_t TRAILER_RST = '{state: T_IDLE, default: '0};

	// Ratios below two cannot make a high and a low half
	function automatic logic [DIV_W-1:0] clampDiv(input logic [DIV_W-1:0] r);
		clampDiv = (r < DIV_MIN) ? DIV_MIN : r;
	endfunction

	function automatic logic [DIV_W-1:0] stepDiv(input logic [DIV_W-1:0] c,
		input logic [DIV_W-1:0] r);
		stepDiv = (c >= clampDiv(r) - DIV_ONE) ? DIV_ZERO : c + DIV_ONE;
	endfunction

	function automatic logic highHalf(input logic [DIV_W-1:0] c, input logic [DIV_W-1:0] r);
		highHalf = c < (clampDiv(r) >> 1);
	endfunction

	trailer_t q;
	trailer_t d;

	always_comb begin
		logic req;
		logic fbWrap;
		logic rise;
		logic fall;
		logic [NUM_OUT-1:0][DIV_W-1:0] nxt;
		logic [NUM_OUT-1:0] nOut;
		req = 1'b0;
		fbWrap = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		nxt = '0;
		nOut = '0;
		d = q;
		d.locked = pllLocked;
		req = link.multiFunctionAlignPin | link.softwareAlignBit;
		d.sync = {q.sync[SYNC_STAGES-2:0], req};
		fbWrap = (q.fbCnt >= clampDiv(loopFeedbackDivider) - DIV_ONE);
		d.fbCnt = stepDiv(q.fbCnt, loopFeedbackDivider);
		d.fbOut = highHalf(d.fbCnt, loopFeedbackDivider);
		if (LOOP_PART) begin
			// Edges act only on a feedback divider boundary
			d.reqRetimed = fbWrap ? q.sync[SYNC_STAGES-1] : q.reqRetimed;
		end else begin
			d.reqRetimed = q.sync[SYNC_STAGES-1];
		end
		d.reqPrev = q.reqRetimed;
		rise = q.reqRetimed & ~q.reqPrev;
		fall = ~q.reqRetimed & q.reqPrev;
		for (int i = 0; i < NUM_OUT; i++) begin
			nxt[i] = stepDiv(q.cnt[i], divRatio[i]);
			nOut[i] = highHalf(nxt[i], divRatio[i]);
		end
		unique case (q.state)
			T_IDLE: begin
				d.cnt = nxt;
				d.out = nOut;
				if (rise) begin
					d.state = T_INIT;
				end
			end
			T_INIT: begin
				for (int i = 0; i < NUM_OUT; i++) begin
					if (!q.frozen[i]) begin
						if (q.out[i] && !nOut[i]) begin
							d.frozen[i] = 1'b1;
							d.out[i] = 1'b0;
						end else begin
							d.cnt[i] = nxt[i];
							d.out[i] = nOut[i];
						end
					end
				end
				if (&q.frozen) begin
					d.state = T_FROZEN;
				end
				// An early release still arms cleanly rather than hanging
				if (fall) begin
					d.state = T_ARM;
				end
			end
			T_FROZEN: begin
				if (fall) begin
					d.state = T_ARM;
				end
			end
			T_ARM: begin
				// Park every divider one step before its high half
				for (int i = 0; i < NUM_OUT; i++) begin
					d.cnt[i] = clampDiv(divRatio[i]) - DIV_ONE;
				end
				d.out = '0;
				d.frozen = '0;
				d.state = T_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q <= TRAILER_RST;
		end else begin
			q <= d;
		end
	end

	assign clkOut = q.out;
	assign frozen = q.frozen;
	assign fbOut = q.fbOut;
	assign phase = q.state;
	assign link.locked = q.locked;

endmodule
`default_nettype wire

//--- verilog/cascade_leader.sv
// Behaviour
// - start only once all parts configured
// - idle keeps pin and bit low
// - part ORs pin with bit
// - one source per event, other low
// - part synchronises request to input clock
// - loop parts retime to feedback divider
// - raise pin or write bit to start
// - retimed rise starts initialisation
// - dividers freeze low at natural fall
// - hold request high at least 1ms
// - drop the same source to complete
// - retimed fall starts completion
// - arm dividers, then release together
// - finish stage one before stage two
// - wait for stage two relock
// - stage two may resync alone anytime
// - one shared request for stage two
// - return idle, all sources low
// - stage two reference divider set one
`timescale 1ns/1ns
`default_nettype none
module cascade_leader #(
	parameter logic [align_pkg::CNT_W-1:0] HOLD_CYCLES = align_pkg::HOLD_MIN_CYC,
	parameter logic [align_pkg::CNT_W-1:0] RELOCK_CYCLES = align_pkg::RELOCK_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	align_if.leader stageOne,
	align_if.leader stageTwo,
	input wire logic start,
	input wire logic trailerOnly,
	input wire logic useSoftware,
	input wire logic configured,
	input wire logic lockEarly,
	input wire logic [align_pkg::CNT_W-1:0] holdCycles,
	input wire logic [align_pkg::CNT_W-1:0] relockCycles,
	output logic busy,
	output logic done,
	output logic startRefused,
	output logic relockLate,
	output align_pkg::leader_state_t phase
);
	import align_pkg::*;

	typedef struct packed {
		leader_state_t state;
		logic [CNT_W-1:0] cnt;
		logic useBit;
		logic s1Pin;
		logic s1Bit;
		logic s2Pin;
		logic s2Bit;
		logic busy;
		logic done;
		logic startRefused;
		logic relockLate;
	} leader_t;

	localparam leader_t LEADER_RST = '{state: L_IDLE, default: '0};

	function automatic logic [CNT_W-1:0] maxCnt(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		maxCnt = (a > b) ? a : b;
	endfunction

	// True on the last cycle of a wait of lim cycles, never shorter than one
	function automatic logic waitOver(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
		waitOver = (c >= maxCnt(lim, CNT_ONE) - CNT_ONE);
	endfunction

	leader_t q;
	leader_t d;

	always_comb begin
		logic [CNT_W-1:0] holdEff;
		logic [CNT_W-1:0] relockEff;
		logic lockedNow;
		holdEff = '0;
		relockEff = '0;
		lockedNow = 1'b0;
		d = q;
		d.done = 1'b0;
		d.startRefused = 1'b0;
		// A short programmed hold is stretched to the safe minimum
		holdEff = maxCnt(holdCycles, HOLD_CYCLES);
		relockEff = (relockCycles == CNT_ZERO) ? RELOCK_CYCLES : relockCycles;
		lockedNow = stageTwo.locked;
		unique case (q.state)
			L_IDLE: begin
				d.s1Pin = 1'b0;
				d.s1Bit = 1'b0;
				d.s2Pin = 1'b0;
				d.s2Bit = 1'b0;
				d.busy = 1'b0;
				d.cnt = CNT_ZERO;
				if (start) begin
					if (!configured) begin
						d.startRefused = 1'b1;
					end else begin
						d.busy = 1'b1;
						d.useBit = useSoftware;
						d.relockLate = 1'b0;
						if (trailerOnly) begin
							// Stage two alone, stage one stays idle
							d.s2Pin = ~useSoftware;
							d.s2Bit = useSoftware;
							d.state = L_S2_INIT;
						end else begin
							d.s1Pin = ~useSoftware;
							d.s1Bit = useSoftware;
							d.state = L_S1_INIT;
						end
					end
				end
			end
			L_S1_INIT: begin
				d.cnt = q.cnt + CNT_ONE;
				if (waitOver(q.cnt, holdEff)) begin
					d.s1Pin = 1'b0;
					d.s1Bit = 1'b0;
					d.cnt = CNT_ZERO;
					d.state = L_S1_DONE;
				end
			end
			L_S1_DONE: begin
				// Completion inside stage one must finish first
				d.cnt = q.cnt + CNT_ONE;
				if (waitOver(q.cnt, SETTLE_CYC)) begin
					d.cnt = CNT_ZERO;
					d.state = L_RELOCK;
				end
			end
			L_RELOCK: begin
				d.cnt = q.cnt + CNT_ONE;
				// Lock seen too soon may be the stale one from before the pause
				if ((lockEarly && lockedNow && waitOver(q.cnt, LOCK_MIN_CYC))
					|| waitOver(q.cnt, relockEff)) begin
					d.relockLate = ~lockedNow;
					d.cnt = CNT_ZERO;
					// Every stage two part shares this one request
					d.s2Pin = ~q.useBit;
					d.s2Bit = q.useBit;
					d.state = L_S2_INIT;
				end
			end
			L_S2_INIT: begin
				d.cnt = q.cnt + CNT_ONE;
				if (waitOver(q.cnt, holdEff)) begin
					d.s2Pin = 1'b0;
					d.s2Bit = 1'b0;
					d.cnt = CNT_ZERO;
					d.state = L_S2_DONE;
				end
			end
			L_S2_DONE: begin
				d.cnt = q.cnt + CNT_ONE;
				if (waitOver(q.cnt, SETTLE_CYC)) begin
					d.cnt = CNT_ZERO;
					d.busy = 1'b0;
					d.done = 1'b1;
					d.state = L_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q <= LEADER_RST;
		end else begin
			q <= d;
		end
	end

	// Stage two alignment to stage one holds only with reference divider one
	assign stageOne.multiFunctionAlignPin = q.s1Pin;
	assign stageOne.softwareAlignBit = q.s1Bit;
	assign stageTwo.multiFunctionAlignPin = q.s2Pin;
	assign stageTwo.softwareAlignBit = q.s2Bit;
	assign busy = q.busy;
	assign done = q.done;
	assign startRefused = q.startRefused;
	assign relockLate = q.relockLate;
	assign phase = q.state;

endmodule
`default_nettype wire

//--- dv/align_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module align_asserts #(
	parameter logic [align_pkg::CNT_W-1:0] HOLD_CYCLES = align_pkg::HOLD_MIN_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic multiFunctionAlignPin,
	input wire logic softwareAlignBit,
	input wire logic locked
);
	import align_pkg::*;
	typedef struct packed {
		logic [CNT_W-1:0] pinCnt;
		logic [CNT_W-1:0] bitCnt;
	} hold_t;
	hold_t hold_q;
	hold_t hold_d;
	// Run lengths of each source, too long for a repetition count
	always_comb begin
		hold_d = hold_q;
		hold_d.pinCnt = multiFunctionAlignPin ? hold_q.pinCnt + CNT_ONE : CNT_ZERO;
		hold_d.bitCnt = softwareAlignBit ? hold_q.bitCnt + CNT_ONE : CNT_ZERO;
	end
	always_ff @(posedge core_clk) begin
		hold_q <= srst ? '0 : hold_d;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_pinDrop;
		multiFunctionAlignPin ##1 !multiFunctionAlignPin;
	endsequence
	sequence s_bitDrop;
		softwareAlignBit ##1 !softwareAlignBit;
	endsequence
	property p_oneSource;
		!(multiFunctionAlignPin && softwareAlignBit);
	endproperty
	property p_idleReset;
		$past(srst) |-> !multiFunctionAlignPin && !softwareAlignBit;
	endproperty
	property p_pinHold;
		s_pinDrop |-> hold_q.pinCnt >= HOLD_CYCLES;
	endproperty
	property p_bitHold;
		s_bitDrop |-> hold_q.bitCnt >= HOLD_CYCLES;
	endproperty
	property p_pinDropAlone;
		$fell(multiFunctionAlignPin) |-> !softwareAlignBit;
	endproperty
	property p_bitDropAlone;
		$fell(softwareAlignBit) |-> !multiFunctionAlignPin;
	endproperty
	property p_pinRest;
		s_pinDrop |=> !multiFunctionAlignPin [*8];
	endproperty
	property p_bitRest;
		s_bitDrop |=> !softwareAlignBit [*8];
	endproperty
	a_oneSource: assert property (p_oneSource) else $error("both sources high");
	a_idleReset: assert property (p_idleReset) else $error("source high after reset");
	a_pinHold: assert property (p_pinHold) else $error("pin high too short");
	a_bitHold: assert property (p_bitHold) else $error("bit high too short");
	a_pinDropAlone: assert property (p_pinDropAlone) else $error("bit high at pin fall");
	a_bitDropAlone: assert property (p_bitDropAlone) else $error("pin high at bit fall");
	a_pinRest: assert property (p_pinRest) else $error("pin back high at once");
	a_bitRest: assert property (p_bitRest) else $error("bit back high at once");
	c_lockedStart: cover property (locked ##1 $rose(multiFunctionAlignPin));
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import align_pkg::*;
	localparam logic [CNT_W-1:0] HOLD = 32'h0000_0028;
	localparam logic [CNT_W-1:0] RELOCK = 32'h0000_001E;
	localparam logic [NUM_OUT-1:0][DIV_W-1:0] RAT = {8'h05, 8'h04, 8'h03, 8'h02};
	localparam int STL = int'(SETTLE_CYC);
	logic core_clk, srst, start, trailerOnly, useSoftware, configured, lockEarly, pllLocked;
	logic busy, done, startRefused, relockLate;
	logic [CNT_W-1:0] holdCycles, relockCycles;
	logic [NUM_OUT-1:0] clkTwo, frozenTwo;
	logic fbTwo;
	trailer_state_t phaseOne, phaseTwo;
	int mismatches, totalChecks;
	align_if ifOne();
	align_if ifTwo();
	cascade_leader #(.HOLD_CYCLES(HOLD), .RELOCK_CYCLES(RELOCK)) cascade_leader_inst (
		.core_clk(core_clk), .srst(srst), .stageOne(ifOne), .stageTwo(ifTwo), .start(start),
		.trailerOnly(trailerOnly), .useSoftware(useSoftware), .configured(configured),
		.lockEarly(lockEarly), .holdCycles(holdCycles), .relockCycles(relockCycles),
		.busy(busy), .done(done), .startRefused(startRefused), .relockLate(relockLate), .phase());
	cascade_trailer #(.LOOP_PART(1'b0)) cascade_trailer_inst1 (.core_clk(core_clk), .srst(srst),
		.link(ifOne), .loopFeedbackDivider(8'h04), .divRatio(RAT), .pllLocked(pllLocked),
		.clkOut(), .frozen(), .fbOut(), .phase(phaseOne));
	cascade_trailer #(.LOOP_PART(1'b1)) cascade_trailer_inst2 (.core_clk(core_clk), .srst(srst),
		.link(ifTwo), .loopFeedbackDivider(8'h04), .divRatio(RAT), .pllLocked(pllLocked),
		.clkOut(clkTwo), .frozen(frozenTwo), .fbOut(fbTwo), .phase(phaseTwo));
	align_asserts #(.HOLD_CYCLES(HOLD)) align_asserts_inst (.core_clk(core_clk), .srst(srst),
		.multiFunctionAlignPin(ifTwo.multiFunctionAlignPin),
		.softwareAlignBit(ifTwo.softwareAlignBit), .locked(ifTwo.locked));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic giveVerdict();
		if (mismatches == 0 && totalChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// One event end to end, watching both links cycle by cycle
	task automatic runEvent(input logic sw, input logic only, input logic early,
			input logic lockV, input logic [CNT_W-1:0] relock, input logic expLate,
			output int gap, output int span);
		int r1 = -1, i1 = -1, r2 = -1, i2 = -1;
		logic one, two, bad = 1'b0, frz = 1'b0, armSeen = 1'b0, fbLast = 1'b0;
		logic [1:0] arm = 2'b00;
		logic [1:0] fbPair = 2'b00;
		gap = 0;
		span = 0;
		@(posedge core_clk);
		useSoftware <= sw;
		trailerOnly <= only;
		lockEarly <= early;
		pllLocked <= lockV;
		relockCycles <= relock;
		start <= 1'b1;
		// The edge that takes start is the first one watched
		do begin
			@(posedge core_clk);
			start <= 1'b0;
			#1;
			span++;
			one = ifOne.multiFunctionAlignPin | ifOne.softwareAlignBit;
			two = ifTwo.multiFunctionAlignPin | ifTwo.softwareAlignBit;
			bad |= (one & two) | (sw ? ifOne.multiFunctionAlignPin | ifTwo.multiFunctionAlignPin
				: ifOne.softwareAlignBit | ifTwo.softwareAlignBit);
			if (one && r1 < 0) r1 = span;
			if (two && r2 < 0) r2 = span;
			if (phaseOne === T_INIT && i1 < 0) i1 = span;
			if (phaseTwo === T_INIT && i2 < 0) begin
				i2 = span;
				fbPair = {fbLast, fbTwo};
			end
			fbLast = fbTwo;
			if (r1 >= 0 && r2 < 0 && !one) gap++;
			// Armed dividers stay low one cycle, then all rise together
			if (arm[0]) check(32'(clkTwo), 32'h0000_0000);
			if (arm[1]) check(32'(clkTwo), 32'h0000_000F);
			armSeen |= arm[1];
			arm = {arm[0], phaseTwo === T_ARM};
			if (phaseTwo === T_FROZEN && !frz) check(32'({clkTwo, frozenTwo}), 32'h0000_000F);
			frz |= (phaseTwo === T_FROZEN);
		end while (span < 3000 && done !== 1'b1);
		check(32'({busy, done}), 32'h0000_0001);
		check(32'(bad), 32'h0000_0000);
		check(32'(r1 >= 0), 32'(!only));
		if (!only) check(32'(i1 - r1), 32'h0000_0005);
		check(32'(i2 - r2 >= 5 && i2 - r2 <= 8), 32'h0000_0001);
		// Initialisation starts one cycle after a feedback wrap
		check(32'(fbPair), 32'h0000_0003);
		check(32'(relockLate), 32'(expLate));
		check(32'({frz, armSeen}), 32'h0000_0003);
	endtask
	task automatic testRefuse();
		@(posedge core_clk);
		configured <= 1'b0;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		configured <= 1'b1;
		#1;
		check(32'({startRefused, busy}), 32'h0000_0002);
	endtask
	// Early lock off, so the full relock wait must pass, and lock withheld, so it is flagged
	task automatic testPinFull();
		int gap, span;
		runEvent(1'b0, 1'b0, 1'b0, 1'b0, CNT_ZERO, 1'b1, gap, span);
		check(32'(gap), 32'(STL + int'(RELOCK)));
	endtask
	task automatic testBitEarly();
		int gap, span;
		runEvent(1'b1, 1'b0, 1'b1, 1'b1, 32'h0000_00C8, 1'b0, gap, span);
		check(32'(gap), 32'(STL + int'(LOCK_MIN_CYC)));
	endtask
	task automatic testTrailerOnly();
		int gap, span;
		@(posedge core_clk);
		holdCycles <= 32'h0000_0032;
		runEvent(1'b1, 1'b1, 1'b0, 1'b1, CNT_ZERO, 1'b0, gap, span);
		check(32'(span), 32'(51 + STL));
	endtask
	initial begin
		srst = 1'b1;
		start = 1'b0;
		trailerOnly = 1'b0;
		useSoftware = 1'b0;
		configured = 1'b1;
		lockEarly = 1'b0;
		pllLocked = 1'b1;
		holdCycles = CNT_ZERO;
		relockCycles = CNT_ZERO;
		mismatches = 0;
		totalChecks = 0;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		testRefuse();
		testPinFull();
		testBitEarly();
		testTrailerOnly();
		giveVerdict();
	end
	// About two and a half times the expected run length
	initial begin
		#40000;
		mismatches++;
		giveVerdict();
	end
endmodule
`default_nettype wire
